/* File: ifee_pkg.sv */
// ifee_pkg: function codes, register map, field layout and timing counts
// shared by the oil timer, the top level, the checker and the bench.
package ifee_pkg;
  // input function codes (16 bit, decimal as configured)
  localparam logic [15:0] FN_NONE        = 16'h0000;
  localparam logic [15:0] FN_STATUS_BASE = 16'h0c87; // 3207
  localparam logic [15:0] FN_STATUS_LAST = 16'h0c8f; // 3215
  localparam logic [15:0] FN_STATUS_FIRST= 16'h0c81; // 3201
  localparam logic [15:0] FN_STATUS_END  = 16'h0c90; // 3216
  localparam logic [15:0] FN_PUMP_START  = 16'h0ce5; // 3301
  localparam logic [15:0] FN_PUMP_STOP   = 16'h0ce6; // 3302
  localparam logic [15:0] FN_WARN        = 16'h0fa1; // 4001
  localparam logic [15:0] FN_UNLOAD      = 16'h0fa2; // 4002
  localparam logic [15:0] FN_DEACT       = 16'h0fa3; // 4003
  localparam logic [15:0] FN_ALARM       = 16'h0fa4; // 4004
  localparam logic [15:0] FN_OIL_WARN    = 16'h0fab; // 4011
  localparam logic [15:0] FN_OIL_UNLOAD  = 16'h0fac; // 4012
  localparam logic [15:0] FN_OIL_DEACT   = 16'h0fad; // 4013
  localparam logic [15:0] FN_OIL_ALARM   = 16'h0fae; // 4014
  localparam logic [15:0] FN_BRK_WARN    = 16'h0fb5; // 4021
  localparam logic [15:0] FN_BRK_UNLOAD  = 16'h0fb6; // 4022
  localparam logic [15:0] FN_BRK_DEACT   = 16'h0fb7; // 4023
  localparam logic [15:0] FN_BRK_ALARM   = 16'h0fb8; // 4024
  localparam logic [15:0] FN_FUEL_WARN   = 16'h0fbf; // 4031
  localparam logic [15:0] FN_FUEL_ALARM  = 16'h0fc2; // 4034
  localparam logic [15:0] FN_GAS_WARN    = 16'h0fc9; // 4041
  localparam logic [15:0] FN_GAS_ALARM   = 16'h0fcc; // 4044
  // first displayable status page number (3201 shows page 6)
  localparam logic [3:0]  PAGE_FIRST     = 4'h6;

  // register map (byte addresses)
  localparam logic [7:0]  ADDR_STATUS    = 8'h00;
  localparam logic [7:0]  ADDR_MASK      = 8'h04;
  localparam logic [7:0]  ADDR_OILDLY    = 8'h08;
  localparam logic [7:0]  ADDR_LEVEL     = 8'h0c;
  localparam logic [7:0]  ADDR_PAGE      = 8'h10;
  localparam logic [7:0]  ADDR_FUNC_BASE = 8'h40;

  // event bit positions in status, mask and level registers
  localparam int EV_WARN   = 0;
  localparam int EV_UNLOAD = 1;
  localparam int EV_DEACT  = 2;
  localparam int EV_ALARM  = 3;
  localparam int EV_PAGE   = 4;
  localparam int EV_W      = 5;

  // oil delay is held in seconds, counted with a 1 ms tick
  localparam int  CLK_HZ       = 250_000_000;
  localparam int  TICK_US      = 1000;
  localparam int  TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_US;
  localparam int  MS_PER_S     = 1000;
  localparam logic [15:0] OILDLY_RESET = 16'h000a;
  localparam logic [7:0]  PAGE_RESET   = 8'h00;
  localparam logic [EV_W-1:0] MASK_RESET = 5'h00;

  typedef enum logic [1:0] {
    IFEE_OIL_STOPPED = 2'b00,
    IFEE_OIL_TIMING  = 2'b01,
    IFEE_OIL_DONE    = 2'b11
  } ifee_oil_t;
endpackage

/* File: ifee_sync.sv */
// ifee_sync: three-flop synchroniser with agreement filter for field pins.
// assumes i_d is asynchronous to i_clk.
`timescale 1ns/1ps
module ifee_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end
    else
    begin
      s1 <= i_d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // only bits whose last two stages agree are allowed to change
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_q <= '0;
    else
      o_q <= (s2 & s3) | (o_q & (s2 | s3));
  end
endmodule // ifee_sync

/* File: ifee_oil_timer.sv */
// ifee_oil_timer: reports when the oil delay has run since engine running.
// assumes i_running is already synchronous; delay in seconds, 1 ms tick.
`timescale 1ns/1ps
module ifee_oil_timer #(
  parameter int TICK_CYCLES = ifee_pkg::TICK_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_running,
  input  wire logic [15:0] i_delay_s,
  output logic             o_elapsed
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  logic [TW-1:0]  tick_cnt;
  logic           tick;
  logic [9:0]     ms_cnt;
  logic [15:0]    sec_cnt;
  ifee_pkg::ifee_oil_t state;

  assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      tick_cnt <= '0;
    else if (tick || !i_running)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + TW'(1);
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state   <= ifee_pkg::IFEE_OIL_STOPPED;
      ms_cnt  <= '0;
      sec_cnt <= '0;
    end
    else if (!i_running)
    begin
      state   <= ifee_pkg::IFEE_OIL_STOPPED;
      ms_cnt  <= '0;
      sec_cnt <= '0;
    end
    else
    begin
      case (state)
        ifee_pkg::IFEE_OIL_STOPPED:
          state <= ifee_pkg::IFEE_OIL_TIMING;
        ifee_pkg::IFEE_OIL_TIMING:
        begin
          if (sec_cnt >= i_delay_s)
            state <= ifee_pkg::IFEE_OIL_DONE;
          else if (tick)
          begin
            if (ms_cnt == 10'(ifee_pkg::MS_PER_S - 1))
            begin
              ms_cnt  <= '0;
              sec_cnt <= sec_cnt + 16'h0001;
            end
            else
              ms_cnt <= ms_cnt + 10'h001;
          end
        end
        ifee_pkg::IFEE_OIL_DONE:
          state <= ifee_pkg::IFEE_OIL_DONE;
        default:
          state <= ifee_pkg::IFEE_OIL_STOPPED;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_elapsed <= 1'b0;
    else
      o_elapsed <= i_running && (state == ifee_pkg::IFEE_OIL_DONE);
  end
endmodule // ifee_oil_timer

/* File: ifee_top.sv */
// ifee_top: evaluates the function assigned to each digital input and turns
// active inputs into status page requests, fuel pump commands and severity
// events. assumes field inputs are asynchronous pins and the breaker, fuel,
// gas and engine running commands come from logic on the same clock.
// Function
// - plain status input shows its page text
// - important status input also forces page display
// - pump start level input starts fuel pump
// - pump stop level input stops fuel pump
// - generic warning input raises warning unconditionally
// - generic unload input raises unload unconditionally
// - generic deactivation input raises deactivation unconditionally
// - generic alarm input raises blocking alarm
// - oil-delay alarm only after delay elapsed
// - oil-delay deactivation only after delay elapsed
// - oil-delay warning/unload raise alarm after delay
// - breaker warning needs breaker close command
// - breaker unload needs breaker close command
// - breaker deactivation needs breaker close command
// - breaker interlock needs breaker close command
// - fuel warning needs fuel solenoid command
// - fuel unload/deactivation/interlock need fuel solenoid
// - gas functions need gas solenoid command
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
module ifee_top #(
  parameter int N_IN        = 8,
  parameter int TICK_CYCLES = ifee_pkg::TICK_CYCLES
) (
  input  wire logic            i_clk,
  input  wire logic            i_arst_n,
  input  wire logic [N_IN-1:0] i_field_in,
  input  wire logic            i_engine_running,
  input  wire logic            i_generator_breaker_cmd,
  input  wire logic            i_fuel_solenoid_cmd,
  input  wire logic            i_gas_solenoid_cmd,
  input  wire logic [7:0]      i_addr,
  input  wire logic [31:0]     i_wdata,
  input  wire logic            i_wr,
  input  wire logic            i_rd,
  output logic      [31:0]     o_rdata,
  output logic                 o_warning,
  output logic                 o_unload,
  output logic                 o_deactivation,
  output logic                 o_alarm,
  output logic                 o_pump_start,
  output logic                 o_pump_stop,
  output logic      [15:0]     o_page_text_req,
  output logic      [15:0]     o_page_show_req,
  output logic      [N_IN-1:0] o_text_active,
  output logic                 o_irq
);
  localparam int EW = ifee_pkg::EV_W;

  logic [N_IN-1:0]   in_sync;
  logic              oil_elapsed;
  logic [15:0]       input_function_code [N_IN];
  logic [15:0]       oil_delay_s;
  logic [EW-1:0]     status;
  logic [EW-1:0]     mask;
  logic [EW-1:0]     level;
  logic [EW-1:0]     level_q;
  logic [EW-1:0]     rise;
  logic [N_IN-1:0]   in_warn;
  logic [N_IN-1:0]   in_unload;
  logic [N_IN-1:0]   in_deact;
  logic [N_IN-1:0]   in_alarm;
  logic [N_IN-1:0]   in_pstart;
  logic [N_IN-1:0]   in_pstop;
  logic [N_IN-1:0]   in_text;
  logic [15:0]       page_text [N_IN];
  logic [15:0]       page_show [N_IN];
  logic [15:0]       next_page_text;
  logic [15:0]       next_page_show;

  ifee_sync #(
    .W (N_IN)
  ) u_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_d      (i_field_in),
    .o_q      (in_sync)
  );

  ifee_oil_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_oil (
    .i_clk     (i_clk),
    .i_arst_n  (i_arst_n),
    .i_running (i_engine_running),
    .i_delay_s (oil_delay_s),
    .o_elapsed (oil_elapsed)
  );

  // one-hot page bit for a status function code; bit n is page n
  function automatic logic [15:0] page_bit(input logic [15:0] code);
    logic [15:0] off;
    logic [3:0]  page;
    off  = code - ifee_pkg::FN_STATUS_FIRST;
    page = 4'(off[4:1]) + ifee_pkg::PAGE_FIRST;
    page_bit = 16'h0001 << page;
  endfunction

  function automatic logic is_status(input logic [15:0] code);
    is_status = (code >= ifee_pkg::FN_STATUS_FIRST) && (code <= ifee_pkg::FN_STATUS_END);
  endfunction

  // per-input decode; combinational so the flags follow the inputs each cycle
  generate
    for (genvar g = 0; g < N_IN; g++)
    begin : g_eval
      logic [15:0] fc;
      logic        act;
      assign fc  = input_function_code[g];
      assign act = in_sync[g];

      always_comb
      begin
        in_warn[g]   = 1'b0;
        in_unload[g] = 1'b0;
        in_deact[g]  = 1'b0;
        in_alarm[g]  = 1'b0;
        in_pstart[g] = 1'b0;
        in_pstop[g]  = 1'b0;
        page_text[g] = 16'h0000;
        page_show[g] = 16'h0000;
        if (act)
        begin
          case (fc)
            ifee_pkg::FN_PUMP_START: in_pstart[g] = 1'b1;
            ifee_pkg::FN_PUMP_STOP:  in_pstop[g]  = 1'b1;
            ifee_pkg::FN_WARN:       in_warn[g]   = 1'b1;
            ifee_pkg::FN_UNLOAD:     in_unload[g] = 1'b1;
            ifee_pkg::FN_DEACT:      in_deact[g]  = 1'b1;
            ifee_pkg::FN_ALARM:      in_alarm[g]  = 1'b1;
            // warning/unload after oil delay act as a block, as documented
            ifee_pkg::FN_OIL_WARN,
            ifee_pkg::FN_OIL_UNLOAD: in_alarm[g]  = oil_elapsed;
            ifee_pkg::FN_OIL_DEACT:  in_deact[g]  = oil_elapsed;
            ifee_pkg::FN_OIL_ALARM:  in_alarm[g]  = oil_elapsed;
            ifee_pkg::FN_BRK_WARN:   in_warn[g]   = i_generator_breaker_cmd;
            ifee_pkg::FN_BRK_UNLOAD: in_unload[g] = i_generator_breaker_cmd;
            ifee_pkg::FN_BRK_DEACT:  in_deact[g]  = i_generator_breaker_cmd;
            ifee_pkg::FN_BRK_ALARM:  in_alarm[g]  = i_generator_breaker_cmd;
            default:
            begin
              if (fc >= ifee_pkg::FN_FUEL_WARN && fc <= ifee_pkg::FN_FUEL_ALARM)
              begin
                // fuel-qualified group, order warn/unload/deact/interlock
                in_warn[g]   = i_fuel_solenoid_cmd && (fc == ifee_pkg::FN_FUEL_WARN);
                in_unload[g] = i_fuel_solenoid_cmd && (fc == ifee_pkg::FN_FUEL_WARN + 16'h0001);
                in_deact[g]  = i_fuel_solenoid_cmd && (fc == ifee_pkg::FN_FUEL_WARN + 16'h0002);
                in_alarm[g]  = i_fuel_solenoid_cmd && (fc == ifee_pkg::FN_FUEL_ALARM);
              end
              else if (fc >= ifee_pkg::FN_GAS_WARN && fc <= ifee_pkg::FN_GAS_ALARM)
              begin
                in_warn[g]   = i_gas_solenoid_cmd && (fc == ifee_pkg::FN_GAS_WARN);
                in_unload[g] = i_gas_solenoid_cmd && (fc == ifee_pkg::FN_GAS_WARN + 16'h0001);
                in_deact[g]  = i_gas_solenoid_cmd && (fc == ifee_pkg::FN_GAS_WARN + 16'h0002);
                in_alarm[g]  = i_gas_solenoid_cmd && (fc == ifee_pkg::FN_GAS_ALARM);
              end
              else if (is_status(fc))
              begin
                page_text[g] = page_bit(fc);
                // even codes are the important variant: force the page up
                page_show[g] = fc[0] ? 16'h0000 : page_bit(fc);
              end
            end
          endcase
        end
      end
      assign in_text[g] = act && (fc != ifee_pkg::FN_NONE);
    end
  endgenerate

  always_comb
  begin
    next_page_text = 16'h0000;
    next_page_show = 16'h0000;
    for (int k = 0; k < N_IN; k++)
    begin
      next_page_text = next_page_text | page_text[k] | page_show[k];
      next_page_show = next_page_show | page_show[k];
    end
  end

  assign level[ifee_pkg::EV_WARN]   = |in_warn;
  assign level[ifee_pkg::EV_UNLOAD] = |in_unload;
  assign level[ifee_pkg::EV_DEACT]  = |in_deact;
  assign level[ifee_pkg::EV_ALARM]  = |in_alarm;
  assign level[ifee_pkg::EV_PAGE]   = |next_page_show;
  assign rise = level & ~level_q;

  // event outputs registered every cycle; no latching so a cleared input
  // drops its request, sequencing logic owns any latching
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_warning       <= 1'b0;
      o_unload        <= 1'b0;
      o_deactivation  <= 1'b0;
      o_alarm         <= 1'b0;
      o_pump_start    <= 1'b0;
      o_pump_stop     <= 1'b0;
      o_page_text_req <= 16'h0000;
      o_page_show_req <= 16'h0000;
      o_text_active   <= '0;
      level_q         <= '0;
    end
    else
    begin
      o_warning       <= level[ifee_pkg::EV_WARN];
      o_unload        <= level[ifee_pkg::EV_UNLOAD];
      o_deactivation  <= level[ifee_pkg::EV_DEACT];
      o_alarm         <= level[ifee_pkg::EV_ALARM];
      o_pump_start    <= |in_pstart;
      o_pump_stop     <= |in_pstop;
      o_page_text_req <= next_page_text;
      o_page_show_req <= next_page_show;
      o_text_active   <= in_text;
      level_q         <= level;
    end
  end

  // configuration registers
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mask        <= ifee_pkg::MASK_RESET;
      oil_delay_s <= ifee_pkg::OILDLY_RESET;
      for (int k = 0; k < N_IN; k++)
        input_function_code[k] <= ifee_pkg::FN_NONE;
    end
    else if (i_wr)
    begin
      if (i_addr == ifee_pkg::ADDR_MASK)
        mask <= i_wdata[EW-1:0];
      if (i_addr == ifee_pkg::ADDR_OILDLY)
        oil_delay_s <= i_wdata[15:0];
      for (int k = 0; k < N_IN; k++)
        if (i_addr == ifee_pkg::ADDR_FUNC_BASE + 8'(4 * k))
          input_function_code[k] <= i_wdata[15:0];
    end
  end

  // sticky status: a rising event wins over a write-one clear
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      status <= '0;
    else if (i_wr && i_addr == ifee_pkg::ADDR_STATUS)
      status <= (status & ~i_wdata[EW-1:0]) | rise;
    else
      status <= status | rise;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_irq <= 1'b0;
    else
      o_irq <= |(status & mask);
  end

  // read data valid only in the cycle after the strobe; zero otherwise
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_rdata <= 32'h0000_0000;
    else
    begin
      o_rdata <= 32'h0000_0000;
      if (i_rd)
      begin
        case (i_addr)
          ifee_pkg::ADDR_STATUS: o_rdata <= 32'(status);
          ifee_pkg::ADDR_MASK:   o_rdata <= 32'(mask);
          ifee_pkg::ADDR_OILDLY: o_rdata <= 32'(oil_delay_s);
          ifee_pkg::ADDR_LEVEL:  o_rdata <= {26'h0, oil_elapsed, level};
          ifee_pkg::ADDR_PAGE:   o_rdata <= {next_page_show, next_page_text};
          default:
          begin
            for (int k = 0; k < N_IN; k++)
              if (i_addr == ifee_pkg::ADDR_FUNC_BASE + 8'(4 * k))
                o_rdata <= 32'(input_function_code[k]);
          end
        endcase
      end
    end
  end
endmodule // ifee_top

/* File: ifee_contacts.sv */
// ifee_contacts: field contacts in front of the evaluator's digital inputs.
// assumes the bench commands closure; pins lag it by a fixed delay.
`timescale 1ns/1ps
module ifee_contacts #(
  parameter int DELAY_NS = 7
) (
  input  wire logic [7:0] i_close,
  output logic      [7:0] o_contact
);
  initial o_contact = 8'h00;
  always @(i_close) o_contact <= #(DELAY_NS) i_close;
endmodule // ifee_contacts

/* File: ifee_top_assertions.sv */
// ifee_top_assertions: port checker for the input function event evaluator.
// assumes one clock; code and oil delay registers are shadowed from bus writes.
`timescale 1ns/1ps
module ifee_top_checker #(
  parameter int N_IN        = 8,
  parameter int TICK_CYCLES = 4
) (
  input wire logic            i_clk,
  input wire logic            i_arst_n,
  input wire logic [N_IN-1:0] i_field_in,
  input wire logic            i_engine_running,
  input wire logic            i_generator_breaker_cmd,
  input wire logic            i_fuel_solenoid_cmd,
  input wire logic            i_gas_solenoid_cmd,
  input wire logic [7:0]      i_addr,
  input wire logic [31:0]     i_wdata,
  input wire logic            i_wr,
  input wire logic            i_rd,
  input wire logic [31:0]     o_rdata,
  input wire logic            o_warning,
  input wire logic            o_unload,
  input wire logic            o_deactivation,
  input wire logic            o_alarm,
  input wire logic            o_pump_start,
  input wire logic            o_pump_stop,
  input wire logic [15:0]     o_page_text_req,
  input wire logic [15:0]     o_page_show_req,
  input wire logic [N_IN-1:0] o_text_active,
  input wire logic            o_irq
);
  logic [15:0] codes [N_IN];
  logic [15:0] oil_sh;
  logic [3:0]  quiet;
  logic [5:0]  cls;
  logic [5:0]  cls_q;
  logic [5:0]  gate;
  logic        any_ev;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      for (int k = 0; k < N_IN; k++)
        codes[k] <= 16'h0000;
      oil_sh <= ifee_pkg::OILDLY_RESET;
    end
    else if (i_wr)
    begin
      if (i_addr[7:6] == 2'b01 && i_addr[1:0] == 2'b00 && i_addr[5:2] < N_IN)
        codes[i_addr[5:2]] <= i_wdata[15:0];
      if (i_addr == ifee_pkg::ADDR_OILDLY)
        oil_sh <= i_wdata[15:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      quiet <= 4'h0;
    else if (i_field_in != '0)
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  end

  // class bits 0-3 stay set only while every input holds none or that class,
  // bits 4-5 only while no input holds the pump start/stop code;
  // the registered copy keeps a fresh code change out of the antecedent
  always_comb
  begin
    cls = 6'h3f;
    for (int k = 0; k < N_IN; k++)
    begin
      if (codes[k] != 16'h0 && (codes[k] < ifee_pkg::FN_BRK_WARN ||
          codes[k] > ifee_pkg::FN_BRK_ALARM))
        cls[0] = 1'b0;
      if (codes[k] != 16'h0 && (codes[k] < ifee_pkg::FN_FUEL_WARN ||
          codes[k] > ifee_pkg::FN_FUEL_ALARM))
        cls[1] = 1'b0;
      if (codes[k] != 16'h0 && (codes[k] < ifee_pkg::FN_GAS_WARN ||
          codes[k] > ifee_pkg::FN_GAS_ALARM))
        cls[2] = 1'b0;
      if (codes[k] != 16'h0 && (codes[k] < ifee_pkg::FN_OIL_WARN ||
          codes[k] > ifee_pkg::FN_OIL_ALARM))
        cls[3] = 1'b0;
      if (codes[k] == ifee_pkg::FN_PUMP_START)
        cls[4] = 1'b0;
      if (codes[k] == ifee_pkg::FN_PUMP_STOP)
        cls[5] = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      cls_q <= 6'h3f;
    else
      cls_q <= cls;
  end

  assign gate = cls & cls_q;
  assign any_ev = o_warning | o_unload | o_deactivation | o_alarm;

  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  oil_read_a: assert property ($past(i_rd) && $past(i_addr) == ifee_pkg::ADDR_OILDLY
    |-> o_rdata == {16'h0, $past(oil_sh)})
    else $error("oil delay read back differs from last write");
  irq_mask_a: assert property (i_wr && i_addr == ifee_pkg::ADDR_MASK && i_wdata[4:0] == 5'h0
    |-> ##3 !o_irq)
    else $error("interrupt high with all events masked");
  quiet_input_a: assert property (quiet >= 4'h7 |-> !any_ev && !o_pump_start && !o_pump_stop
    && o_text_active == '0 && o_page_text_req == 16'h0)
    else $error("request raised with all field inputs inactive");
  brk_gate_a: assert property (gate[0] && !$past(i_generator_breaker_cmd) |-> !any_ev)
    else $error("breaker qualified event without breaker command");
  fuel_gate_a: assert property (gate[1] && !$past(i_fuel_solenoid_cmd) |-> !any_ev)
    else $error("fuel qualified event without fuel solenoid command");
  gas_gate_a: assert property (gate[2] && !$past(i_gas_solenoid_cmd) |-> !any_ev)
    else $error("gas qualified event without gas solenoid command");
  oil_gate_a: assert property ((!i_engine_running)[*4] ##0 gate[3] |-> !any_ev)
    else $error("oil delay event while engine stopped");
  pump_code_a: assert property (!(gate[4] && o_pump_start) && !(gate[5] && o_pump_stop))
    else $error("pump command without a pump level input");
  page_map_a: assert property ((o_page_show_req & ~o_page_text_req) == 16'h0
    && o_page_text_req[5:0] == 6'h0 && o_page_text_req[15:14] == 2'h0)
    else $error("page request outside the status pages");
endmodule // ifee_top_checker

bind ifee_top ifee_top_checker #(.N_IN(N_IN), .TICK_CYCLES(TICK_CYCLES)) chk_u (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_field_in(i_field_in),
  .i_engine_running(i_engine_running), .i_generator_breaker_cmd(i_generator_breaker_cmd),
  .i_fuel_solenoid_cmd(i_fuel_solenoid_cmd), .i_gas_solenoid_cmd(i_gas_solenoid_cmd),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_warning(o_warning), .o_unload(o_unload), .o_deactivation(o_deactivation),
  .o_alarm(o_alarm), .o_pump_start(o_pump_start), .o_pump_stop(o_pump_stop),
  .o_page_text_req(o_page_text_req), .o_page_show_req(o_page_show_req),
  .o_text_active(o_text_active), .o_irq(o_irq));

/* File: ifee_top_bench.sv */
// ifee_top_bench: self-checking bench for the input function evaluator.
// assumes a short tick (1 s = 4000 cycles) and the contact model on pins.
`timescale 1ns/1ps
module ifee_top_bench;
  localparam int TICK = 4;
  // {function code, {breaker, fuel, gas}, {warn, unload, deact, alarm, start, stop}}
  localparam logic [24:0] ROWS [20] = '{
    {ifee_pkg::FN_WARN, 3'b000, 6'b100000}, {ifee_pkg::FN_UNLOAD, 3'b000, 6'b010000},
    {ifee_pkg::FN_DEACT, 3'b000, 6'b001000}, {ifee_pkg::FN_ALARM, 3'b000, 6'b000100},
    {ifee_pkg::FN_PUMP_START, 3'b000, 6'b000010}, {ifee_pkg::FN_PUMP_STOP, 3'b000, 6'b000001},
    {ifee_pkg::FN_BRK_WARN, 3'b100, 6'b100000}, {16'h0fb6, 3'b100, 6'b010000},
    {16'h0fb7, 3'b100, 6'b001000}, {ifee_pkg::FN_BRK_ALARM, 3'b100, 6'b000100},
    {ifee_pkg::FN_FUEL_WARN, 3'b010, 6'b100000}, {16'h0fc0, 3'b010, 6'b010000},
    {16'h0fc1, 3'b010, 6'b001000}, {ifee_pkg::FN_FUEL_ALARM, 3'b010, 6'b000100},
    {ifee_pkg::FN_GAS_WARN, 3'b001, 6'b100000}, {16'h0fca, 3'b001, 6'b010000},
    {16'h0fcb, 3'b001, 6'b001000}, {ifee_pkg::FN_GAS_ALARM, 3'b001, 6'b000100},
    {ifee_pkg::FN_OIL_WARN, 3'b000, 6'b000000}, {ifee_pkg::FN_OIL_ALARM, 3'b000, 6'b000000}};

  logic        clk    = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  close  = 8'h00;
  logic [7:0]  field;
  logic        run    = 1'b0;
  logic        brk    = 1'b0;
  logic        fuel   = 1'b0;
  logic        gas    = 1'b0;
  logic [7:0]  addr   = 8'h00;
  logic [31:0] wdata  = 32'h0;
  logic        wr     = 1'b0;
  logic        rd     = 1'b0;
  logic [31:0] rdata;
  logic [15:0] text_req;
  logic [15:0] show_req;
  logic [7:0]  text_act;
  logic        irq;
  logic [31:0] ev;
  logic        w, u, dv, al, ps, pp;
  int          fails  = 0;
  int          total_checks = 0;

  assign ev = {26'h0, w, u, dv, al, ps, pp};
  always #2 clk = ~clk;

  ifee_contacts #(.DELAY_NS(7)) field_u (.i_close(close), .o_contact(field));

  ifee_top #(.N_IN(8), .TICK_CYCLES(TICK)) dut_u (
    .i_clk(clk), .i_arst_n(arst_n), .i_field_in(field), .i_engine_running(run),
    .i_generator_breaker_cmd(brk), .i_fuel_solenoid_cmd(fuel), .i_gas_solenoid_cmd(gas),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_warning(w), .o_unload(u), .o_deactivation(dv), .o_alarm(al), .o_pump_start(ps),
    .o_pump_stop(pp), .o_page_text_req(text_req), .o_page_show_req(show_req),
    .o_text_active(text_act), .o_irq(irq));

  task automatic close_out;
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end

  initial
  begin
    logic [31:0] d;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    wait_cyc(2);
    reg_rd(ifee_pkg::ADDR_OILDLY, d);
    check(d, {16'h0, ifee_pkg::OILDLY_RESET});
    reg_rd(8'h20, d);
    check(d, 32'h0);
    for (int r = 0; r < 20; r++)
    begin
      reg_wr(ifee_pkg::ADDR_FUNC_BASE, {16'h0, ROWS[r][24:9]});
      {brk, fuel, gas} <= ROWS[r][8:6];
      close <= 8'h01;
      wait_cyc(8);
      check(ev, {26'h0, ROWS[r][5:0]});
      if (ROWS[r][8:6] != 3'b000)
      begin
        {brk, fuel, gas} <= 3'b000;
        wait_cyc(3);
        check(ev, 32'h0);
      end
      close <= 8'h00;
      wait_cyc(8);
      check(ev, 32'h0);
    end
    // two plain, one important status input
    reg_wr(8'h44, 32'h0c87);
    reg_wr(8'h48, 32'h0c8e);
    reg_wr(8'h4c, 32'h0c8f);
    close <= 8'h0e;
    wait_cyc(8);
    check({16'h0, text_req}, 32'h3200);
    check({16'h0, show_req}, 32'h1000);
    check({24'h0, text_act}, 32'h0e);
    reg_rd(ifee_pkg::ADDR_PAGE, d);
    check(d, 32'h10003200);
    close <= 8'h00;
    reg_wr(ifee_pkg::ADDR_STATUS, 32'h1f);
    reg_wr(ifee_pkg::ADDR_FUNC_BASE, {16'h0, ifee_pkg::FN_WARN});
    reg_wr(ifee_pkg::ADDR_MASK, 32'h1);
    close <= 8'h01;
    wait_cyc(8);
    check({31'h0, irq}, 32'h1);
    reg_wr(ifee_pkg::ADDR_MASK, 32'h0);
    wait_cyc(3);
    check({31'h0, irq}, 32'h0);
    reg_wr(ifee_pkg::ADDR_MASK, 32'h1);
    close <= 8'h00;
    wait_cyc(8);
    reg_rd(ifee_pkg::ADDR_STATUS, d);
    check(d, 32'h1);
    reg_wr(ifee_pkg::ADDR_STATUS, 32'h1);
    wait_cyc(3);
    check({31'h0, irq}, 32'h0);
    // one second oil delay, four-cycle tick
    reg_wr(ifee_pkg::ADDR_OILDLY, 32'h1);
    reg_wr(ifee_pkg::ADDR_FUNC_BASE, {16'h0, ifee_pkg::FN_OIL_ALARM});
    close <= 8'h01;
    run <= 1'b1;
    wait_cyc(3950);
    check(ev, 32'h0);
    wait_cyc(100);
    check(ev, 32'h04);
    reg_wr(ifee_pkg::ADDR_FUNC_BASE, {16'h0, ifee_pkg::FN_OIL_DEACT});
    wait_cyc(3);
    check(ev, 32'h08);
    reg_wr(ifee_pkg::ADDR_FUNC_BASE, {16'h0, ifee_pkg::FN_OIL_UNLOAD});
    wait_cyc(3);
    check(ev, 32'h04);
    run <= 1'b0;
    wait_cyc(4);
    check(ev, 32'h0);
    // reset in mid-run while a warning stands
    reg_wr(ifee_pkg::ADDR_FUNC_BASE, {16'h0, ifee_pkg::FN_WARN});
    wait_cyc(3);
    check(ev, 32'h20);
    arst_n <= 1'b0;
    wait_cyc(2);
    check({25'h0, irq, ev[5:0]}, 32'h0);
    arst_n <= 1'b1;
    wait_cyc(8);
    check(ev, 32'h0);
    reg_rd(ifee_pkg::ADDR_FUNC_BASE, d);
    check(d, 32'h0);
    reg_rd(ifee_pkg::ADDR_OILDLY, d);
    check(d, {16'h0, ifee_pkg::OILDLY_RESET});
    close <= 8'h00;
    close_out();
  end
endmodule // ifee_top_bench
